// ==== src/cip_cfg.svh ====
`ifndef CIP_CFG_SVH
`define CIP_CFG_SVH
// register addresses
`define CIP_ADDR_CTRL      32'hffd00000
`define CIP_ADDR_PRIO_A    32'hffd00004
`define CIP_ADDR_PRIO_B    32'hffd00008
`define CIP_ADDR_PRIO_C    32'hffd0000c
`define CIP_ADDR_PRIO_D    32'hffd00010
`define CIP_ADDR_DBG_FLAG  32'hffd00014
// reset values
`define CIP_CTRL_RST_HI    16'h8000
`define CIP_CTRL_RST_LO    16'h0000
`define CIP_PRIO_RST       16'h0000
`define CIP_PRIO_D_RST     16'hda74
// control register field positions
`define CIP_CTRL_PIN_BIT   15
`define CIP_CTRL_BLKOV_BIT 14
`define CIP_CTRL_EDGE_BIT  8
`define CIP_CTRL_LMODE_BIT 7
// event codes
`define CIP_EVT_UNMASK     12'h1c0
`define CIP_EVT_DEBUG      12'h600
`define CIP_EVT_LINE_BASE  12'h200
`define CIP_EVT_LINE_STEP  12'h020
`define CIP_EVT_NONE       12'h000
// levels and timing
`define CIP_LVL_UNMASK     5'h10
`define CIP_EDGE_HOLD_CYC  3'h6
`endif

// ==== src/cip_pkg.sv ====
package cip_pkg;
   typedef logic [3:0]  cip_level_t;
   typedef logic [11:0] cip_code_t;
   typedef enum logic [1:0]
   {
      CIP_PWR_NORMAL  = 2'b00,
      CIP_PWR_SLEEP   = 2'b01,
      CIP_PWR_STANDBY = 2'b10
   } cip_pwr_e;
   typedef enum logic [1:0]
   {
      CIP_EDGE_ARMED = 2'b00,
      CIP_EDGE_HOLD  = 2'b01
   } cip_edge_e;
endpackage : cip_pkg

// ==== src/cip_unmask_if.sv ====
`timescale 1ns/1ps
interface cip_unmask_if;
   logic pin_sync;
   logic edge_rise;
   logic edge_changed;
   logic pend_clear;
   logic pending;
   modport detector
   (
      input  pin_sync,
      input  edge_rise,
      input  edge_changed,
      input  pend_clear,
      output pending
   );
   modport owner
   (
      output pin_sync,
      output edge_rise,
      output edge_changed,
      output pend_clear,
      input  pending
   );
endinterface : cip_unmask_if

// ==== src/cip_unmask_edge.sv ====
`timescale 1ns/1ps
`include "cip_cfg.svh"
module cip_unmask_edge
(
   input  wire logic         core_clk_in,
   input  wire logic         sys_rst_in,
   cip_unmask_if.detector    link
);
   import cip_pkg::*;
   cip_edge_e  state_reg;
   logic [2:0] hold_cnt_reg;
   logic       prev_reg;
   logic       pend_reg;
   logic       hit;

   assign hit = (state_reg == CIP_EDGE_ARMED) &&
                (link.edge_rise ? (link.pin_sync && !prev_reg) : (!link.pin_sync && prev_reg));
   assign link.pending = pend_reg;

   always_ff @(posedge core_clk_in or posedge sys_rst_in)
      if (sys_rst_in)
         prev_reg <= 1'b0;
      else
         prev_reg <= link.pin_sync;

   // edge select change blanks detection; edge across a polarity flip is not a real event
   always_ff @(posedge core_clk_in or posedge sys_rst_in)
      if (sys_rst_in)
      begin
         state_reg    <= CIP_EDGE_ARMED;
         hold_cnt_reg <= 3'h0;
      end
      else
         case (state_reg)
            CIP_EDGE_ARMED:
               if (link.edge_changed)
               begin
                  state_reg    <= CIP_EDGE_HOLD;
                  hold_cnt_reg <= `CIP_EDGE_HOLD_CYC - 3'h1;
               end
            CIP_EDGE_HOLD:
               if (link.edge_changed)
                  hold_cnt_reg <= `CIP_EDGE_HOLD_CYC - 3'h1;
               else if (hold_cnt_reg == 3'h0)
                  state_reg <= CIP_EDGE_ARMED;
               else
                  hold_cnt_reg <= hold_cnt_reg - 3'h1;
            default:
               state_reg <= CIP_EDGE_ARMED;
         endcase

   // set wins over clear
   always_ff @(posedge core_clk_in or posedge sys_rst_in)
      if (sys_rst_in)
         pend_reg <= 1'b0;
      else if (hit)
         pend_reg <= 1'b1;
      else if (link.pend_clear)
         pend_reg <= 1'b0;

   hold_max_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      ($rose(state_reg == CIP_EDGE_HOLD) && !link.edge_changed) ##1 (!link.edge_changed) [*5]
      |=> state_reg == CIP_EDGE_ARMED)
      else $error("edge blanking exceeds six cycles");
   edge_sets_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      hit |=> pend_reg)
      else $error("detected edge did not set pending");
endmodule : cip_unmask_edge

// ==== src/cip_top.sv ====
// Contract
// - every maskable source has a level 0 to 15, 15 highest.
// - level 0 means the source is masked and ignored.
// - unmaskable request ranks at level 16 above all others.
// - unmaskable request accepted unless block bit is 1.
// - in sleep the unmaskable request is accepted regardless of block bit.
// - override control bit lets unmaskable request through despite block bit.
// - unmaskable input edge-detected; control bit picks rising or falling.
// - after edge select changes, detection blanked at most 6 cycles.
// - unmaskable handling leaves the cpu mask level unchanged.
// - control register resets to 0x8000 if pin high, else 0x0000.
// - priority registers a, b, c reset to zero.
// - priority register d resets to 0xda74.
// - all registers initialise on power-on or manual reset; the debug flag clears on power-on only.
// - request lines act as four independent or one encoded request.
// - request lines are masked by the cpu mask level.
// - debug interrupt takes event code 0x600.
// - debug priority comes from bits 3:0 of priority register c.
// - debug request sets when interrupt instruction is loaded.
// - debug request holds until software writes 0 to the flag.
// - debug interrupt or reset accepted in sleep and ends sleep.
// - in standby no debug interrupt or reset is accepted.
// - encoded mode: lines give level directly, 0000 is no request.
// - line mode bit 1 selects independent request operation.
`timescale 1ns/1ps
`include "cip_cfg.svh"
module cip_top
#(
   parameter int MOD_SRCS = 4
)
(
   input  wire logic                        core_clk_in,
   input  wire logic                        sys_rst_in,
   input  wire logic                        manual_rst_in,
   input  wire logic                        unmask_pin_in,
   input  wire logic [3:0]                  encoded_request_lines_in,
   input  wire logic [MOD_SRCS-1:0]         module_req_in,
   input  wire logic                        block_bit_in,
   input  wire cip_pkg::cip_level_t         cpu_mask_level_in,
   input  wire cip_pkg::cip_pwr_e           pwr_mode_in,
   input  wire logic                        dbg_irupt_load_in,
   input  wire logic                        dbg_reset_req_in,
   input  wire logic                        irq_ack_in,
   input  wire logic                        reg_wr_in,
   input  wire logic                        reg_rd_in,
   input  wire logic [31:0]                 reg_addr_in,
   input  wire logic [15:0]                 reg_wdata_in,
   output logic [15:0]                      reg_rdata_out,
   output logic                             irq_req_out,
   output cip_pkg::cip_level_t              irq_level_out,
   output logic                             irq_unmask_out,
   output cip_pkg::cip_code_t               event_code_register_out,
   output logic                             wake_out,
   output logic                             dbg_reset_out
);
   import cip_pkg::*;

   logic [15:0] interrupt_control_reg;
   logic [15:0] priority_level_a_reg;
   logic [15:0] priority_level_b_reg;
   logic [15:0] priority_level_c_reg;
   logic [15:0] priority_level_d_reg;
   logic        debug_request_flag_reg;
   logic        unm_meta_reg;
   logic        unm_sync_reg;
   logic [3:0]  irl_meta_reg;
   logic [3:0]  irl_sync_reg;
   logic [1:0]  strap_cnt_reg;
   logic        any_rst;
   logic        wr_ctrl;
   logic        edge_changed;
   logic        line_mode;
   logic        unm_take;
   logic        best_valid;
   cip_level_t  best_level;
   cip_code_t   best_code;
   logic        dbg_accept;

   cip_unmask_if ulink ();

   function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
      hit = (a == b);
   endfunction : hit

   function automatic cip_level_t nib(input logic [15:0] r, input int idx);
      nib = r[idx*4 +: 4];
   endfunction : nib

   // manual reset is a clocked reset; power-on is the async one
   assign any_rst      = manual_rst_in;
   assign wr_ctrl      = reg_wr_in && hit(reg_addr_in, `CIP_ADDR_CTRL);
   assign edge_changed = wr_ctrl &&
      (reg_wdata_in[`CIP_CTRL_EDGE_BIT] != interrupt_control_reg[`CIP_CTRL_EDGE_BIT]);
   assign line_mode    = interrupt_control_reg[`CIP_CTRL_LMODE_BIT];

   // both pins cross from outside the clock domain
   always_ff @(posedge core_clk_in or posedge sys_rst_in)
      if (sys_rst_in)
      begin
         unm_meta_reg <= 1'b0;
         unm_sync_reg <= 1'b0;
         irl_meta_reg <= 4'h0;
         irl_sync_reg <= 4'h0;
      end
      else
      begin
         unm_meta_reg <= unmask_pin_in;
         unm_sync_reg <= unm_meta_reg;
         irl_meta_reg <= encoded_request_lines_in;
         irl_sync_reg <= irl_meta_reg;
      end

   assign ulink.pin_sync     = unm_sync_reg;
   assign ulink.edge_rise    = interrupt_control_reg[`CIP_CTRL_EDGE_BIT];
   assign ulink.edge_changed = edge_changed;
   assign ulink.pend_clear   = irq_ack_in && irq_unmask_out;

   cip_unmask_edge u_cip_unmask_edge
   (
      .core_clk_in (core_clk_in),
      .sys_rst_in  (sys_rst_in),
      .link        (ulink.detector)
   );

   // strap: wait out both synchroniser stages, never peek at the first one
   always_ff @(posedge core_clk_in or posedge sys_rst_in)
      if (sys_rst_in)
         strap_cnt_reg <= 2'h3;
      else if (any_rst)
         strap_cnt_reg <= 2'h3;
      else if (strap_cnt_reg != 2'h0)
         strap_cnt_reg <= strap_cnt_reg - 2'h1;

   always_ff @(posedge core_clk_in or posedge sys_rst_in)
      if (sys_rst_in)
         interrupt_control_reg <= `CIP_CTRL_RST_LO;
      else if (any_rst)
         interrupt_control_reg <= `CIP_CTRL_RST_LO;
      else if (strap_cnt_reg == 2'h1)
         interrupt_control_reg <= unm_sync_reg ? `CIP_CTRL_RST_HI : `CIP_CTRL_RST_LO;
      else if (wr_ctrl)
         interrupt_control_reg <= {unm_sync_reg, reg_wdata_in[14:0]};
      else
         interrupt_control_reg[`CIP_CTRL_PIN_BIT] <= unm_sync_reg;

   always_ff @(posedge core_clk_in or posedge sys_rst_in)
      if (sys_rst_in)
      begin
         priority_level_a_reg <= `CIP_PRIO_RST;
         priority_level_b_reg <= `CIP_PRIO_RST;
         priority_level_c_reg <= `CIP_PRIO_RST;
         priority_level_d_reg <= `CIP_PRIO_D_RST;
      end
      else if (any_rst)
      begin
         priority_level_a_reg <= `CIP_PRIO_RST;
         priority_level_b_reg <= `CIP_PRIO_RST;
         priority_level_c_reg <= `CIP_PRIO_RST;
         priority_level_d_reg <= `CIP_PRIO_D_RST;
      end
      else if (reg_wr_in)
      begin
         if (hit(reg_addr_in, `CIP_ADDR_PRIO_A))
            priority_level_a_reg <= reg_wdata_in;
         if (hit(reg_addr_in, `CIP_ADDR_PRIO_B))
            priority_level_b_reg <= reg_wdata_in;
         if (hit(reg_addr_in, `CIP_ADDR_PRIO_C))
            priority_level_c_reg <= reg_wdata_in;
         if (hit(reg_addr_in, `CIP_ADDR_PRIO_D))
            priority_level_d_reg <= reg_wdata_in;
      end

   // standby drops the debug load; writing 1 keeps the flag, only 0 clears
   always_ff @(posedge core_clk_in or posedge sys_rst_in)
      if (sys_rst_in)
         debug_request_flag_reg <= 1'b0;
      else if (dbg_irupt_load_in && pwr_mode_in != CIP_PWR_STANDBY)
         debug_request_flag_reg <= 1'b1;
      else if (reg_wr_in && hit(reg_addr_in, `CIP_ADDR_DBG_FLAG) && !reg_wdata_in[0])
         debug_request_flag_reg <= 1'b0;

   always_ff @(posedge core_clk_in or posedge sys_rst_in)
      if (sys_rst_in)
         reg_rdata_out <= 16'h0000;
      else if (reg_rd_in)
         case (reg_addr_in)
            `CIP_ADDR_CTRL:     reg_rdata_out <= interrupt_control_reg;
            `CIP_ADDR_PRIO_A:   reg_rdata_out <= priority_level_a_reg;
            `CIP_ADDR_PRIO_B:   reg_rdata_out <= priority_level_b_reg;
            `CIP_ADDR_PRIO_C:   reg_rdata_out <= priority_level_c_reg;
            `CIP_ADDR_PRIO_D:   reg_rdata_out <= priority_level_d_reg;
            `CIP_ADDR_DBG_FLAG: reg_rdata_out <= {15'h0000, debug_request_flag_reg};
            default:            reg_rdata_out <= 16'h0000;
         endcase

   // unmaskable path: block bit gates it unless sleeping or override set
   assign unm_take = ulink.pending &&
      (!block_bit_in || pwr_mode_in == CIP_PWR_SLEEP ||
       interrupt_control_reg[`CIP_CTRL_BLKOV_BIT]);
   assign dbg_accept = debug_request_flag_reg && pwr_mode_in != CIP_PWR_STANDBY;

   // maskable arbitration; first found at a level wins ties, so order sets default rank
   always_comb
   begin
      cip_level_t lv;
      best_valid = 1'b0;
      best_level = 4'h0;
      best_code  = `CIP_EVT_NONE;
      lv         = 4'h0;
      if (line_mode)
      begin
         for (int i = 3; i >= 0; i--)
         begin
            lv = nib(priority_level_d_reg, i);
            // independent line i asserted low; level from register d nibble
            if (!irl_sync_reg[i] && lv != 4'h0 && lv > best_level)
            begin
               best_valid = 1'b1;
               best_level = lv;
               best_code  = `CIP_EVT_LINE_BASE + `CIP_EVT_LINE_STEP * 12'(3 - i);
            end
         end
      end
      else if (irl_sync_reg != 4'h0)
      begin
         best_valid = 1'b1;
         best_level = irl_sync_reg;
         best_code  = `CIP_EVT_LINE_BASE + `CIP_EVT_LINE_STEP * 12'(4'hf - irl_sync_reg);
      end
      lv = nib(priority_level_c_reg, 0);
      if (dbg_accept && lv != 4'h0 && lv > best_level)
      begin
         best_valid = 1'b1;
         best_level = lv;
         best_code  = `CIP_EVT_DEBUG;
      end
      for (int m = 0; m < MOD_SRCS; m++)
      begin
         lv = nib(m < 4 ? priority_level_a_reg : priority_level_b_reg, m % 4);
         if (module_req_in[m] && lv != 4'h0 && lv > best_level)
         begin
            best_valid = 1'b1;
            best_level = lv;
            best_code  = `CIP_EVT_LINE_BASE + 12'h200 + 12'(m) * `CIP_EVT_LINE_STEP;
         end
      end
   end

   // the cpu mask is never written here; exception entry keeps it
   always_ff @(posedge core_clk_in or posedge sys_rst_in)
      if (sys_rst_in)
      begin
         irq_req_out             <= 1'b0;
         irq_level_out           <= 4'h0;
         irq_unmask_out          <= 1'b0;
         event_code_register_out <= `CIP_EVT_NONE;
      end
      else if (unm_take)
      begin
         irq_req_out             <= 1'b1;
         irq_level_out           <= 4'hf;
         irq_unmask_out          <= 1'b1;
         event_code_register_out <= `CIP_EVT_UNMASK;
      end
      else if (best_valid && best_level > cpu_mask_level_in && !block_bit_in)
      begin
         irq_req_out             <= 1'b1;
         irq_level_out           <= best_level;
         irq_unmask_out          <= 1'b0;
         event_code_register_out <= best_code;
      end
      else
      begin
         irq_req_out    <= 1'b0;
         irq_unmask_out <= 1'b0;
      end

   always_ff @(posedge core_clk_in or posedge sys_rst_in)
      if (sys_rst_in)
      begin
         wake_out      <= 1'b0;
         dbg_reset_out <= 1'b0;
      end
      else
      begin
         wake_out      <= pwr_mode_in == CIP_PWR_SLEEP &&
                          (debug_request_flag_reg || dbg_reset_req_in || ulink.pending);
         dbg_reset_out <= dbg_reset_req_in && pwr_mode_in != CIP_PWR_STANDBY;
      end

   // outputs are registered, so each check looks one edge after its cause
   unm_block_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      ulink.pending && block_bit_in && pwr_mode_in == CIP_PWR_NORMAL &&
      !interrupt_control_reg[`CIP_CTRL_BLKOV_BIT] |=> !irq_unmask_out)
      else $error("unmaskable taken while blocked");
   unm_sleep_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      ulink.pending && pwr_mode_in == CIP_PWR_SLEEP |=> irq_unmask_out)
      else $error("unmaskable not taken in sleep");
   unm_override_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      ulink.pending && interrupt_control_reg[`CIP_CTRL_BLKOV_BIT] |=>
      irq_unmask_out && event_code_register_out == `CIP_EVT_UNMASK)
      else $error("override did not pass unmaskable");
   unm_rank_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      unm_take |=> irq_unmask_out)
      else $error("unmaskable lost arbitration");
   dbg_hold_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      debug_request_flag_reg && !(reg_wr_in && hit(reg_addr_in, `CIP_ADDR_DBG_FLAG))
      |=> debug_request_flag_reg)
      else $error("debug flag dropped without clear");
   dbg_standby_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      pwr_mode_in == CIP_PWR_STANDBY |=> !dbg_reset_out)
      else $error("debug reset taken in standby");
   mask_level_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      irq_req_out && !irq_unmask_out |-> irq_level_out > $past(cpu_mask_level_in))
      else $error("request at or below mask level");
   zero_masked_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      irq_req_out && !irq_unmask_out |-> irq_level_out != 4'h0)
      else $error("level zero source presented");
   dbg_code_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      irq_req_out && event_code_register_out == `CIP_EVT_DEBUG |->
      irq_level_out == $past(priority_level_c_reg[3:0]))
      else $error("debug level not from register c");
   strap_load_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      !any_rst && strap_cnt_reg == 2'h1 |=>
      interrupt_control_reg == ($past(unm_sync_reg) ? `CIP_CTRL_RST_HI : `CIP_CTRL_RST_LO))
      else $error("control register strap wrong");
   man_rst_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      any_rst |=> priority_level_a_reg == `CIP_PRIO_RST &&
      priority_level_d_reg == `CIP_PRIO_D_RST)
      else $error("manual reset missed priority registers");
   dbg_set_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      dbg_irupt_load_in && pwr_mode_in != CIP_PWR_STANDBY |=> debug_request_flag_reg)
      else $error("debug load did not set flag");
   encoded_lvl_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      irq_req_out && !irq_unmask_out && !$past(line_mode) && $past(irl_sync_reg) == 4'hf
      |-> irq_level_out == 4'hf)
      else $error("encoded level fifteen not presented");
   wake_sleep_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      wake_out |-> $past(pwr_mode_in) == CIP_PWR_SLEEP)
      else $error("wake raised outside sleep");

   unm_taken_c: cover property (@(posedge core_clk_in) irq_unmask_out);
   dbg_taken_c: cover property (@(posedge core_clk_in)
      irq_req_out && event_code_register_out == `CIP_EVT_DEBUG);
   line_ind_c: cover property (@(posedge core_clk_in) irq_req_out && line_mode);
   wake_c: cover property (@(posedge core_clk_in) wake_out);
   line_enc_c: cover property (@(posedge core_clk_in) irq_req_out && !line_mode && !irq_unmask_out);
endmodule : cip_top

// ==== sim/cip_cpu_model.sv ====
`timescale 1ns/1ps
module cip_cpu_model
(
   input  wire logic                core_clk_in,
   input  wire logic                sys_rst_in,
   input  wire logic                ack_en_in,
   input  wire logic [3:0]          ack_delay_in,
   input  wire logic                irq_req_in,
   input  wire cip_pkg::cip_level_t mask_set_in,
   output logic                     irq_ack_out,
   output cip_pkg::cip_level_t      cpu_mask_level_out
);
   import cip_pkg::*;
   logic [3:0] wait_reg;
   // mask follows software only, taking an unmaskable request never moves it
   always_ff @(posedge core_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         cpu_mask_level_out <= 4'h0;
      else
         cpu_mask_level_out <= mask_set_in;
   end
   // programmable wait; the testbench only ever sets a delay of 3
   always_ff @(posedge core_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         wait_reg    <= 4'h0;
         irq_ack_out <= 1'b0;
      end
      else
      begin
         irq_ack_out <= 1'b0;
         if (ack_en_in && irq_req_in && !irq_ack_out)
         begin
            if (wait_reg >= ack_delay_in)
            begin
               irq_ack_out <= 1'b1;
               wait_reg    <= 4'h0;
            end
            else
               wait_reg <= wait_reg + 4'h1;
         end
         else
            wait_reg <= 4'h0;
      end
   end
endmodule : cip_cpu_model

// ==== sim/cip_top_tb.sv ====
`timescale 1ns/1ps
`include "cip_cfg.svh"
module cip_top_tb;
   import cip_pkg::*;
   logic        core_clk_in, sys_rst_in, man_rst, pin, blk, ld, dbg_rst, wr, rd, ack_en, ack;
   logic [3:0]  lines, mod_req, mask_set, ack_dly;
   logic [31:0] addr;
   logic [15:0] wdata, rdata;
   logic        req, unm, wake, dbg_rst_o;
   cip_pwr_e    pwr;
   cip_level_t  lvl, mask;
   cip_code_t   code;
   int          failures, check_count;
   cip_top u_cip_top
   (
      .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .manual_rst_in(man_rst),
      .unmask_pin_in(pin), .encoded_request_lines_in(lines), .module_req_in(mod_req),
      .block_bit_in(blk), .cpu_mask_level_in(mask), .pwr_mode_in(pwr),
      .dbg_irupt_load_in(ld), .dbg_reset_req_in(dbg_rst), .irq_ack_in(ack),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .irq_req_out(req), .irq_level_out(lvl),
      .irq_unmask_out(unm), .event_code_register_out(code), .wake_out(wake),
      .dbg_reset_out(dbg_rst_o)
   );
   cip_cpu_model u_cip_cpu_model
   (
      .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .ack_en_in(ack_en),
      .ack_delay_in(ack_dly), .irq_req_in(req), .mask_set_in(mask_set),
      .irq_ack_out(ack), .cpu_mask_level_out(mask)
   );
   initial
   begin
      core_clk_in = 1'b0;
      forever #2.5 core_clk_in = ~core_clk_in;
   end
   task automatic final_report();
      if (failures == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask : tick
   task automatic cmp(input logic [31:0] act, input logic [31:0] exp);
      check_count++;
      if (act !== exp)
      begin
         failures++;
         $display("Error t=%0t act=%h exp=%h", $time, act, exp);
      end
   endtask : cmp
   task automatic reg_wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge core_clk_in);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge core_clk_in);
      wr <= 1'b0;
   endtask : reg_wr
   // read data is registered, taken one edge after the strobe drops
   task automatic chk_reg(input logic [31:0] a, input logic [15:0] e);
      @(posedge core_clk_in);
      rd <= 1'b1; addr <= a;
      @(posedge core_clk_in);
      rd <= 1'b0;
      tick(1);
      cmp({16'h0000, rdata}, {16'h0000, e});
   endtask : chk_reg
   // level and code only mean something while a request stands
   task automatic chk_irq(input logic r, input logic u, input cip_level_t l, input cip_code_t c);
      cmp({30'h0, req, unm}, {30'h0, r, u});
      if (r)
         cmp({16'h0, lvl, code}, {16'h0, l, c});
   endtask : chk_irq
   task automatic pin_to(input logic v);
      @(posedge core_clk_in);
      pin <= v;
      tick(6);
   endtask : pin_to
   task automatic dbg_load();
      @(posedge core_clk_in);
      ld <= 1'b1;
      @(posedge core_clk_in);
      ld <= 1'b0;
      tick(3);
   endtask : dbg_load
   task automatic wait_ack();
      int n;
      @(posedge core_clk_in);
      ack_en <= 1'b1;
      tick(1);
      for (n = 0; n < 20 && unm !== 1'b0; n++)
         tick(1);
      if (unm !== 1'b0)
      begin
         failures++;
         final_report();
      end
      @(posedge core_clk_in);
      ack_en <= 1'b0;
   endtask : wait_ack
   initial
   begin
      {man_rst, blk, ld, dbg_rst, wr, rd, ack_en} = 7'h00;
      {lines, mod_req, mask_set} = 12'h000;
      ack_dly = 4'h3; pin = 1'b1; pwr = CIP_PWR_NORMAL;
      addr = 32'h0; wdata = 16'h0; failures = 0; check_count = 0;
      sys_rst_in = 1'b1;
      repeat (6) @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      tick(10);
      chk_reg(`CIP_ADDR_CTRL, `CIP_CTRL_RST_HI);
      chk_reg(`CIP_ADDR_PRIO_A, `CIP_PRIO_RST);
      chk_reg(`CIP_ADDR_PRIO_B, `CIP_PRIO_RST);
      chk_reg(`CIP_ADDR_PRIO_C, `CIP_PRIO_RST);
      chk_reg(`CIP_ADDR_PRIO_D, `CIP_PRIO_D_RST);
      chk_reg(32'hffd00020, 16'h0000);
      // falling edge is selected out of reset
      @(posedge core_clk_in);
      blk <= 1'b1;
      pin_to(1'b0);
      chk_irq(1'b0, 1'b0, 4'h0, 12'h000);
      @(posedge core_clk_in);
      blk <= 1'b0; lines <= 4'hf;
      tick(5);
      chk_irq(1'b1, 1'b1, 4'hf, `CIP_EVT_UNMASK);
      wait_ack();
      tick(2);
      chk_irq(1'b1, 1'b0, 4'hf, `CIP_EVT_LINE_BASE);
      @(posedge core_clk_in);
      lines <= 4'h0; blk <= 1'b1;
      reg_wr(`CIP_ADDR_CTRL, 16'h4100);
      tick(7);
      pin_to(1'b1);
      chk_irq(1'b1, 1'b1, 4'hf, `CIP_EVT_UNMASK);
      wait_ack();
      reg_wr(`CIP_ADDR_CTRL, 16'h0100);
      tick(7);
      @(posedge core_clk_in);
      pwr <= CIP_PWR_SLEEP;
      pin_to(1'b0);
      chk_irq(1'b0, 1'b0, 4'h0, 12'h000);
      pin_to(1'b1);
      chk_irq(1'b1, 1'b1, 4'hf, `CIP_EVT_UNMASK);
      wait_ack();
      @(posedge core_clk_in);
      pwr <= CIP_PWR_NORMAL;
      pin_to(1'b0);
      pin_to(1'b1);
      chk_irq(1'b0, 1'b0, 4'h0, 12'h000);
      @(posedge core_clk_in);
      blk <= 1'b0;
      wait_ack();
      for (int l = 1; l < 16; l++)
      begin
         @(posedge core_clk_in);
         lines <= 4'(l); mask_set <= 4'h0;
         tick(5);
         chk_irq(1'b1, 1'b0, cip_level_t'(l),
                 cip_code_t'(`CIP_EVT_LINE_BASE + `CIP_EVT_LINE_STEP * (15 - l)));
         @(posedge core_clk_in);
         mask_set <= 4'(l);
         tick(5);
         chk_irq(1'b0, 1'b0, 4'h0, 12'h000);
      end
      @(posedge core_clk_in);
      lines <= 4'h0; mask_set <= 4'h0; mod_req <= 4'b0010;
      tick(5);
      chk_irq(1'b0, 1'b0, 4'h0, 12'h000);
      reg_wr(`CIP_ADDR_PRIO_A, 16'h0050);
      tick(3);
      chk_irq(1'b1, 1'b0, 4'h5, 12'h420);
      @(posedge core_clk_in);
      mod_req <= 4'b1010;
      reg_wr(`CIP_ADDR_PRIO_A, 16'h9050);
      tick(3);
      chk_irq(1'b1, 1'b0, 4'h9, 12'h460);
      chk_reg(`CIP_ADDR_PRIO_A, 16'h9050);
      @(posedge core_clk_in);
      mod_req <= 4'h0; lines <= 4'hf;
      reg_wr(`CIP_ADDR_CTRL, 16'h0080);
      tick(5);
      chk_irq(1'b0, 1'b0, 4'h0, 12'h000);
      @(posedge core_clk_in);
      lines <= 4'b1110;
      tick(5);
      chk_irq(1'b1, 1'b0, 4'h4, 12'h260);
      @(posedge core_clk_in);
      lines <= 4'b0110;
      tick(5);
      chk_irq(1'b1, 1'b0, 4'hd, 12'h200);
      reg_wr(`CIP_ADDR_CTRL, 16'h0000);
      @(posedge core_clk_in);
      lines <= 4'h0;
      reg_wr(`CIP_ADDR_PRIO_C, 16'h0007);
      dbg_load();
      chk_irq(1'b1, 1'b0, 4'h7, `CIP_EVT_DEBUG);
      chk_reg(`CIP_ADDR_DBG_FLAG, 16'h0001);
      reg_wr(`CIP_ADDR_DBG_FLAG, 16'h0001);
      tick(3);
      chk_irq(1'b1, 1'b0, 4'h7, `CIP_EVT_DEBUG);
      reg_wr(`CIP_ADDR_DBG_FLAG, 16'h0000);
      tick(3);
      chk_irq(1'b0, 1'b0, 4'h0, 12'h000);
      @(posedge core_clk_in);
      pwr <= CIP_PWR_SLEEP;
      dbg_load();
      cmp({31'h0, wake}, 32'h1);
      reg_wr(`CIP_ADDR_DBG_FLAG, 16'h0000);
      @(posedge core_clk_in);
      pwr <= CIP_PWR_STANDBY;
      tick(3);
      dbg_load();
      chk_irq(1'b0, 1'b0, 4'h0, 12'h000);
      @(posedge core_clk_in);
      dbg_rst <= 1'b1;
      tick(3);
      cmp({30'h0, wake, dbg_rst_o}, 32'h0);
      @(posedge core_clk_in);
      pwr <= CIP_PWR_SLEEP;
      tick(3);
      cmp({30'h0, wake, dbg_rst_o}, 32'h3);
      @(posedge core_clk_in);
      dbg_rst <= 1'b0; pwr <= CIP_PWR_NORMAL;
      reg_wr(`CIP_ADDR_PRIO_B, 16'h1234);
      chk_reg(`CIP_ADDR_PRIO_B, 16'h1234);
      @(posedge core_clk_in);
      man_rst <= 1'b1;
      @(posedge core_clk_in);
      man_rst <= 1'b0;
      tick(2);
      chk_reg(`CIP_ADDR_PRIO_B, `CIP_PRIO_RST);
      chk_reg(`CIP_ADDR_PRIO_C, `CIP_PRIO_RST);
      chk_reg(`CIP_ADDR_PRIO_D, `CIP_PRIO_D_RST);
      chk_reg(`CIP_ADDR_CTRL, `CIP_CTRL_RST_HI);
      final_report();
   end
endmodule : cip_top_tb
